// ### logic/rtc_host_defs.vh
/*
  Constants for the two-wire host controller that talks to the clock chip.
  Assumes inclusion by bare name from the controller source.
*/
`ifndef RTC_HOST_DEFS_VH
`define RTC_HOST_DEFS_VH

// ----------------------------------------------------------------------
// Control registers of the controller (byte addresses, Avalon-MM)
// ----------------------------------------------------------------------
`define REG_CTRL        4'h0
`define REG_STATUS      4'h4
`define REG_WDATA       4'h8
`define REG_RDATA       4'hc
`define CTRL_GO_BIT     0
`define CTRL_READ_BIT   1
`define CTRL_CUR_BIT    2
`define CTRL_ADDR_LSB   8
`define CTRL_CNT_LSB    16
`define CTRL_RESET      32'h00000000

// ----------------------------------------------------------------------
// Device register map and addressing
// ----------------------------------------------------------------------
`define DEV_ID          7'h5a  // Arbitrary value, set to the fitted part's code
`define DEV_LAST_LOC    8'h13
`define USER_BYTE_0     8'h12
`define USER_BYTE_1     8'h13

// ----------------------------------------------------------------------
// Timing: 400 kHz bus, quarter period in core cycles at 125 MHz
// ----------------------------------------------------------------------
`define CORE_HZ         125000000
`define BUS_HZ          400000
`define QTR_CYCLES      ((`CORE_HZ / `BUS_HZ) / 4)
`define QTR_W           7

`endif

// ### logic/rtc_i2c_host.v
/*
  Two-wire bus master for the clock chip's register array: byte writes,
  random or current-address sequential reads.
  Assumes an external pull-up on both lines and a single Avalon-MM master.
*/
// Decided for this implementation: the Avalon-MM slave port.
// Behaviour
// - Every byte is shifted most significant bit first.
// - Data changes only with clock low; high-clock changes mark START/STOP.
// - Transmitter releases data after eight bits; receiver pulls low on ninth.
// - Master acknowledges each read byte when more bytes are wanted.
// - First byte holds 7-bit identifier then direction bit, 1 read.
// - One word address byte follows the slave address byte.
// - Random read uses identical slave address in both phases.
// - Write is START, address, word address, one data byte, STOP.
// - Read is START, addr+0, word address, repeated START, addr+1.
// - Device sends bytes while acknowledged; master ends with STOP.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_host_defs.vh"

module rtc_i2c_host
(
  input  wire        CORE_CLK_IN,
  input  wire        SYS_RST_IN,
  input  wire [3:0]  AVS_ADDRESS_IN,
  input  wire        AVS_READ_IN,
  input  wire        AVS_WRITE_IN,
  input  wire [31:0] AVS_WRITEDATA_IN,
  output reg  [31:0] AVS_READDATA_OUT,
  output reg         AVS_WAITREQUEST_OUT,
  input  wire        SCL_IN,
  output reg         SCL_OUT,
  output reg         SCL_OE_OUT,
  input  wire        SDA_IN,
  output reg         SDA_OUT,
  output reg         SDA_OE_OUT
);

  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam [3:0] ST_IDLE  = 4'h0;
  localparam [3:0] ST_START = 4'h1;
  localparam [3:0] ST_BIT   = 4'h2;
  localparam [3:0] ST_ACK   = 4'h3;
  localparam [3:0] ST_STOP  = 4'h4;
  localparam [3:0] ST_RSTRT = 4'h5;

  localparam [2:0] PH_ADDRW = 3'h0;
  localparam [2:0] PH_WORD  = 3'h1;
  localparam [2:0] PH_WDATA = 3'h2;
  localparam [2:0] PH_ADDRR = 3'h3;
  localparam [2:0] PH_RDATA = 3'h4;

  // Divider end count, cut to the counter width on purpose
  localparam integer      QTR_END = (`QTR_CYCLES) - 1;
  localparam [`QTR_W-1:0] QTR_MAX = QTR_END[`QTR_W-1:0];

  reg  [3:0]        state_q;
  reg  [2:0]        phase_q;
  reg  [1:0]        quarter_q;
  reg  [`QTR_W-1:0] div_q;
  reg  [2:0]        bit_q;
  reg  [7:0]        shift_q;
  reg  [7:0]        word_q;
  reg  [7:0]        wdata_q;
  reg  [7:0]        rdata_q;
  reg  [7:0]        count_q;
  reg               is_read_q;
  reg               use_cur_q;
  reg               busy_q;
  reg               nack_q;
  reg               done_q;
  reg               lost_q;
  reg  [1:0]        sda_sync_q;
  reg  [1:0]        scl_sync_q;
  wire              tick;
  wire              sda_s;

  assign sda_s = sda_sync_q[1];
  assign tick  = (div_q == QTR_MAX);

  // --------------------------------------------------------------------
  // Input synchronisers for the bus lines
  // --------------------------------------------------------------------
  always @(posedge CORE_CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      sda_sync_q <= 2'h3;
      scl_sync_q <= 2'h3;
    end
    else
    begin
      sda_sync_q <= {sda_sync_q[0], SDA_IN};
      scl_sync_q <= {scl_sync_q[0], SCL_IN};
    end
  end

  // --------------------------------------------------------------------
  // Quarter-bit enable divider
  // --------------------------------------------------------------------
  always @(posedge CORE_CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      div_q <= {`QTR_W{1'b0}};
    else if (tick || state_q == ST_IDLE)
      div_q <= {`QTR_W{1'b0}};
    else
      div_q <= div_q + 1'b1;
  end

  // --------------------------------------------------------------------
  // Avalon-MM slave: one wait cycle on every access
  // --------------------------------------------------------------------
  always @(posedge CORE_CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      AVS_WAITREQUEST_OUT <= 1'b1;
      AVS_READDATA_OUT    <= 32'h00000000;
    end
    else
    begin
      AVS_WAITREQUEST_OUT <= ~(AVS_WAITREQUEST_OUT & (AVS_READ_IN | AVS_WRITE_IN));
      case (AVS_ADDRESS_IN)
        `REG_CTRL:   AVS_READDATA_OUT <= {8'h00, count_q, word_q, 5'h00, use_cur_q,
                                          is_read_q, busy_q};
        `REG_STATUS: AVS_READDATA_OUT <= {28'h0000000, lost_q, nack_q, done_q, busy_q};
        `REG_WDATA:  AVS_READDATA_OUT <= {24'h000000, wdata_q};
        `REG_RDATA:  AVS_READDATA_OUT <= {24'h000000, rdata_q};
        default:     AVS_READDATA_OUT <= 32'h00000000;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Transfer sequencer, one step per quarter bit
  // --------------------------------------------------------------------
  wire acc_wr = AVS_WRITE_IN & ~AVS_WAITREQUEST_OUT;
  wire acc_rd = AVS_READ_IN & ~AVS_WAITREQUEST_OUT;

  always @(posedge CORE_CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      state_q    <= ST_IDLE;
      phase_q    <= PH_ADDRW;
      quarter_q  <= 2'h0;
      bit_q      <= 3'h7;
      shift_q    <= 8'h00;
      word_q     <= 8'h00;
      wdata_q    <= 8'h00;
      rdata_q    <= 8'h00;
      count_q    <= 8'h00;
      is_read_q  <= 1'b0;
      use_cur_q  <= 1'b0;
      busy_q     <= 1'b0;
      nack_q     <= 1'b0;
      done_q     <= 1'b0;
      lost_q     <= 1'b0;
      SCL_OUT    <= 1'b0;
      SCL_OE_OUT <= 1'b0;
      SDA_OUT    <= 1'b0;
      SDA_OE_OUT <= 1'b0;
    end
    else
    begin
      // Reading status clears sticky flags; a new event wins
      if (acc_rd && AVS_ADDRESS_IN == `REG_STATUS)
      begin
        done_q <= 1'b0;
        nack_q <= 1'b0;
        lost_q <= 1'b0;
      end
      if (acc_wr && AVS_ADDRESS_IN == `REG_WDATA && !busy_q)
        wdata_q <= AVS_WRITEDATA_IN[7:0];
      case (state_q)
        ST_IDLE:
        begin
          SCL_OE_OUT <= 1'b0;
          SDA_OE_OUT <= 1'b0;
          if (acc_wr && AVS_ADDRESS_IN == `REG_CTRL && AVS_WRITEDATA_IN[`CTRL_GO_BIT])
          begin
            is_read_q <= AVS_WRITEDATA_IN[`CTRL_READ_BIT];
            use_cur_q <= AVS_WRITEDATA_IN[`CTRL_CUR_BIT];
            word_q    <= AVS_WRITEDATA_IN[`CTRL_ADDR_LSB+7:`CTRL_ADDR_LSB];
            count_q   <= AVS_WRITEDATA_IN[`CTRL_CNT_LSB+7:`CTRL_CNT_LSB];
            busy_q    <= 1'b1;
            quarter_q <= 2'h0;
            // Current-address read skips the dummy write
            phase_q   <= (AVS_WRITEDATA_IN[`CTRL_READ_BIT] &
                          AVS_WRITEDATA_IN[`CTRL_CUR_BIT]) ? PH_ADDRR : PH_ADDRW;
            state_q   <= ST_START;
          end
        end
        ST_START, ST_RSTRT:
          if (tick)
          begin
            quarter_q <= quarter_q + 2'h1;
            case (quarter_q)
              2'h0: SDA_OE_OUT <= 1'b0;
              2'h1: SCL_OE_OUT <= 1'b0;
              2'h2:
              begin
                SDA_OE_OUT <= 1'b1;
                if (!scl_sync_q[1])
                  lost_q <= 1'b1;
              end
              default:
              begin
                SCL_OE_OUT <= 1'b1;
                bit_q      <= 3'h7;
                shift_q    <= {`DEV_ID, (phase_q == PH_ADDRR)};
                state_q    <= ST_BIT;
              end
            endcase
          end
        ST_BIT, ST_ACK:
          if (tick)
          begin
            quarter_q <= quarter_q + 2'h1;
            case (quarter_q)
              2'h0:
              begin
                // Drive data while clock low
                if (state_q == ST_BIT)
                  SDA_OE_OUT <= (phase_q == PH_RDATA) ? 1'b0 : ~shift_q[7];
                else
                  SDA_OE_OUT <= (phase_q == PH_RDATA) && (count_q != 8'h01);
              end
              2'h1: SCL_OE_OUT <= 1'b0;
              2'h2:
              begin
                if (state_q == ST_BIT)
                  shift_q <= {shift_q[6:0], sda_s};
                else if (phase_q != PH_RDATA && sda_s)
                  nack_q <= 1'b1;
              end
              default:
              begin
                SCL_OE_OUT <= 1'b1;
                if (state_q == ST_BIT)
                begin
                  bit_q <= bit_q - 3'h1;
                  if (bit_q == 3'h0)
                    state_q <= ST_ACK;
                end
                // Live line, not the flag: a status read may clear the flag
                else if (phase_q != PH_RDATA && sda_s)
                  state_q <= ST_STOP;
                else
                begin
                  state_q <= ST_BIT;
                  bit_q   <= 3'h7;
                  case (phase_q)
                    PH_ADDRW:
                    begin
                      phase_q <= PH_WORD;
                      shift_q <= word_q;
                    end
                    PH_WORD:
                      if (is_read_q)
                      begin
                        phase_q <= PH_ADDRR;
                        state_q <= ST_RSTRT;
                      end
                      else
                      begin
                        phase_q <= PH_WDATA;
                        shift_q <= wdata_q;
                      end
                    PH_WDATA: state_q <= ST_STOP;
                    PH_ADDRR:
                    begin
                      phase_q <= PH_RDATA;
                      if (count_q == 8'h00)
                        state_q <= ST_STOP;
                    end
                    PH_RDATA:
                    begin
                      rdata_q <= shift_q;
                      count_q <= count_q - 8'h01;
                      if (count_q == 8'h01)
                        state_q <= ST_STOP;
                    end
                    default: state_q <= ST_STOP;
                  endcase
                end
              end
            endcase
          end
        ST_STOP:
          if (tick)
          begin
            quarter_q <= quarter_q + 2'h1;
            case (quarter_q)
              2'h0: SDA_OE_OUT <= 1'b1;
              2'h1: SCL_OE_OUT <= 1'b0;
              2'h2: SDA_OE_OUT <= 1'b0;
              default:
              begin
                busy_q  <= 1'b0;
                done_q  <= 1'b1;
                state_q <= ST_IDLE;
              end
            endcase
          end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// ### test/rtc_dev_model.sv
/*
  Behavioural clock chip: two-wire slave over a 20-byte array.
  Assumes the bench resolves the pulled-up lines.
*/
`timescale 1ns/1ps
`default_nettype none
module rtc_dev_model
(
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  input  wire logic [6:0] ID_IN,
  output var  logic       SDA_OE_OUT
);
  logic [7:0] mem [0:19];
  logic [7:0] sh, tx, ptr;
  logic [2:0] st;
  logic       rd;
  int         cnt;
  // Power-up: line released, pointer cleared
  initial
  begin
    SDA_OE_OUT = 1'b0;
    ptr = 8'h00;
    st = 3'h0;
    cnt = 0;
    for (int i = 0; i < 20; i++) mem[i] = 8'ha0 + 8'(i);
  end
  // Start restarts the byte from any state
  always @(negedge SDA_IN)
    if (SCL_IN === 1'b1)
    begin
      st = 3'h1;
      cnt = 0;
    end
  // Stop goes to standby
  always @(posedge SDA_IN)
    if (SCL_IN === 1'b1)
    begin
      st = 3'h0;
      SDA_OE_OUT = 1'b0;
    end
  // Sample on rising clock
  always @(posedge SCL_IN)
    if (st != 3'h0)
    begin
      if (cnt < 8) sh = {sh[6:0], SDA_IN};
      else if (st == 3'h4 && SDA_IN) st = 3'h0;
      cnt++;
    end
  // Acknowledge, pointer and next bit on falling clock
  always @(negedge SCL_IN)
    if (st != 3'h0)
    begin
      if (cnt == 8)
        case (st)
          3'h1: if (sh[7:1] == ID_IN) {SDA_OE_OUT, rd} = {1'b1, sh[0]};
                else st = 3'h0;
          3'h2: {SDA_OE_OUT, ptr} = {1'b1, sh};
          3'h3: {SDA_OE_OUT, mem[ptr[4:0]]} = {1'b1, sh};
          default: SDA_OE_OUT = 1'b0;
        endcase
      else if (cnt == 9)
      begin
        cnt = 0;
        SDA_OE_OUT = 1'b0;
        st = st == 3'h1 ? (rd ? 3'h4 : 3'h2) : st == 3'h2 ? 3'h3 : st == 3'h3 ? 3'h0 : st;
        if (st == 3'h4)
        begin
          tx = mem[ptr[4:0]];
          ptr = ptr == 8'h13 ? 8'h00 : ptr + 8'h01;
          SDA_OE_OUT = ~tx[7];
        end
      end
      else if (st == 3'h4) SDA_OE_OUT = ~tx[3'(7 - cnt)];
    end
endmodule
`default_nettype wire

// ### test/rtc_i2c_host_chk.sv
/*
  Port checker for the two-wire host controller.
  Assumes binding to rtc_i2c_host; sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module rtc_i2c_host_chk
(
  input wire logic        CORE_CLK_IN,
  input wire logic        SYS_RST_IN,
  input wire logic [3:0]  AVS_ADDRESS_IN,
  input wire logic        AVS_READ_IN,
  input wire logic        AVS_WRITE_IN,
  input wire logic [31:0] AVS_READDATA_OUT,
  input wire logic        AVS_WAITREQUEST_OUT,
  input wire logic        SCL_IN,
  input wire logic        SCL_OUT,
  input wire logic        SCL_OE_OUT,
  input wire logic        SDA_OUT,
  input wire logic        SDA_OE_OUT
);
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);
  // --------------------------------
  // Line conditions
  // --------------------------------
  sequence seq_start;
    SCL_IN && !SCL_OE_OUT && $rose(SDA_OE_OUT);
  endsequence
  sequence seq_stop;
    SCL_IN && !SCL_OE_OUT && $fell(SDA_OE_OUT);
  endsequence
  // --------------------------------
  // Bus slave and link timing
  // --------------------------------
  chk_wait_answer: assert property ((AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT
    |=> !AVS_WAITREQUEST_OUT) else $error("waitrequest did not drop after request");
  chk_wait_pulse: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
    else $error("waitrequest low longer than one cycle");
  chk_unmapped_zero: assert property (AVS_READ_IN && AVS_WAITREQUEST_OUT
    && AVS_ADDRESS_IN[1:0] != 2'h0 |=> AVS_READDATA_OUT == 32'h0)
    else $error("unmapped read not zero");
  chk_start_then_low: assert property (seq_start |-> ##[1:90] $rose(SCL_OE_OUT))
    else $error("clock not pulled low after start");
  chk_stop_idle: assert property (seq_stop |=> (!SCL_OE_OUT && !SDA_OE_OUT) [*8])
    else $error("lines not released after stop");
  chk_hold_low: assert property ($rose(SCL_OE_OUT) |=> $stable(SDA_OE_OUT) [*8])
    else $error("data moved at clock fall");
  chk_hold_high: assert property ($fell(SCL_OE_OUT) |=> $stable(SDA_OE_OUT) [*8])
    else $error("data moved while clock high");
  chk_scl_low_time: assert property ($rose(SCL_OE_OUT) |-> ##[150:162] $fell(SCL_OE_OUT))
    else $error("clock low phase wrong length");
  chk_open_drain: assert property (SCL_OUT == 1'b0 && SDA_OUT == 1'b0)
    else $error("line driven high");
endmodule
bind rtc_i2c_host rtc_i2c_host_chk i_chk
(
  .CORE_CLK_IN(CORE_CLK_IN), .SYS_RST_IN(SYS_RST_IN), .AVS_ADDRESS_IN(AVS_ADDRESS_IN),
  .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
  .AVS_READDATA_OUT(AVS_READDATA_OUT), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
  .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT), .SCL_OE_OUT(SCL_OE_OUT),
  .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT)
);
`default_nettype wire

// ### test/rtc_i2c_host_test.sv
/*
  Bench: host controller against the clock chip model.
  Assumes pulled-up lines, resolved here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtc_host_defs.vh"
module rtc_i2c_host_test;
  logic        clk, rst, rd, wr, wrq, scl_oe, sda_oe, dev_oe;
  logic [3:0]  adr;
  logic [31:0] wdat, rdat;
  logic [6:0]  id;
  int          mismatches, n_tests;
  wire logic   scl = ~scl_oe;
  wire logic   sda = ~(sda_oe | dev_oe);
  rtc_i2c_host i_dut
  (
    .CORE_CLK_IN(clk), .SYS_RST_IN(rst), .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd),
    .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdat), .AVS_READDATA_OUT(rdat),
    .AVS_WAITREQUEST_OUT(wrq), .SCL_IN(scl), .SCL_OUT(), .SCL_OE_OUT(scl_oe),
    .SDA_IN(sda), .SDA_OUT(), .SDA_OE_OUT(sda_oe)
  );
  rtc_dev_model i_dev (.SCL_IN(scl), .SDA_IN(sda), .ID_IN(id), .SDA_OE_OUT(dev_oe));
  // Core clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // --------------------------------
  // Shared tasks
  // --------------------------------
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Avalon access: hold until waitrequest sampled low
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    adr <= a;
    rd <= ~w;
    wr <= w;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wrq !== 1'b0 && n < 100);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n == 100)
    begin
      chk(32'hffffffff, 32'h0);
      complete_run;
    end
  endtask
  // Start a transfer, poll to the end, check status, fetch last byte
  task automatic op(input logic [31:0] c, input logic [31:0] m, input logic [31:0] e,
                    output logic [31:0] q);
    int          i;
    logic [31:0] s;
    acc(1'b1, `REG_CTRL, c, q);
    i = 0;
    s = 32'h0;
    // Sticky bits clear on each status read, so gather them over all polls
    do
    begin
      acc(1'b0, `REG_STATUS, 32'h0, q);
      s = s | q;
      i++;
    end
    while (q[0] !== 1'b0 && i < 5000);
    if (q[0] !== 1'b0)
    begin
      chk(32'hffffffff, 32'h0);
      complete_run;
    end
    chk(s & m, e);
    acc(1'b0, `REG_RDATA, 32'h0, q);
  endtask
  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_reset;
    logic [31:0] q;
    acc(1'b0, `REG_CTRL, 32'h0, q);
    chk(q, `CTRL_RESET);
    acc(1'b0, 4'h2, 32'h0, q);
    chk(q, 32'h0);
    op(32'h00010007, 32'h6, 32'h2, q);
    chk(q, 32'ha0);
    $display("test reset done");
  endtask
  task automatic t_rw;
    logic [31:0] q;
    acc(1'b1, `REG_WDATA, 32'h3c, q);
    op({16'h0, `USER_BYTE_0, 8'h01}, 32'h6, 32'h2, q);
    acc(1'b1, `REG_WDATA, 32'hc3, q);
    op({16'h0, `USER_BYTE_1, 8'h01}, 32'h6, 32'h2, q);
    op({8'h0, 8'h01, `USER_BYTE_0, 8'h03}, 32'h6, 32'h2, q);
    chk(q, 32'h3c);
    op(32'h00010007, 32'h6, 32'h2, q);
    chk(q, 32'hc3);
    op(32'h00020007, 32'h6, 32'h2, q);
    chk(q, 32'ha1);
    $display("test write read done");
  endtask
  task automatic t_nack;
    logic [31:0] q;
    id = ~`DEV_ID;
    op({16'h0, `USER_BYTE_0, 8'h01}, 32'h4, 32'h4, q);
    id = `DEV_ID;
    op(32'h00010007, 32'h6, 32'h2, q);
    chk(q, 32'ha2);
    $display("test nack done");
  endtask
  // Main sequence
  initial
  begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = 4'h0;
    wdat = 32'h0;
    id = `DEV_ID;
    mismatches = 0;
    n_tests = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_rw;
    t_nack;
    complete_run;
  end
endmodule
`default_nettype wire
